/* design/psbs_defines.vh */
// psbs_defines.vh: offsets, field positions and reset values of the
// parallel slave buffer status block.
// assumes: included by bare name from the design files under design/.
`ifndef PSBS_DEFINES_VH
`define PSBS_DEFINES_VH

// register byte offsets on the apb bus
`define PSBS_ADDR_W 8
`define PSBS_OFS_STATUS 8'h00
`define PSBS_OFS_CTRL 8'h04
`define PSBS_OFS_INT_STATUS 8'h08
`define PSBS_OFS_INT_MASK 8'h0C

// parallel_slave_status field positions
`define PSBS_BIT_IN_ALL_FULL 15
`define PSBS_BIT_IN_OVERFLOW 14
`define PSBS_IN_FULL_HI 11
`define PSBS_IN_FULL_LO 8
`define PSBS_BIT_OUT_ALL_EMPTY 7
`define PSBS_BIT_OUT_UNDERFLOW 6
`define PSBS_OUT_EMPTY_HI 3
`define PSBS_OUT_EMPTY_LO 0
`define PSBS_STATUS_RESET 32'h0000008F

// control register
`define PSBS_BIT_SLAVE_EN 0
`define PSBS_CTRL_RESET 1'b0

// interrupt status and mask layout
`define PSBS_INT_W 4
`define PSBS_INT_OVERFLOW 0
`define PSBS_INT_UNDERFLOW 1
`define PSBS_INT_IN_FULL 2
`define PSBS_INT_OUT_EMPTY 3
`define PSBS_INT_RESET 4'h0

// buffer count and synchroniser depth
`define PSBS_NBUF 4
`define PSBS_SYNC_STAGES 2

`endif

/* design/psbs_flag.v */
// psbs_flag.v: one sticky status flag with set and clear inputs.
// assumes: set and clear are single-cycle pulses on pclk.
module psbs_flag #(
    parameter RESET_VAL = 1'b0
)
(
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire set_i,
    input wire clr_i,
    // state
    output reg flag_reg
);

    // set has priority so an event coinciding with a clear is kept
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_reg <= RESET_VAL;
        end
        else if (set_i)
        begin
            flag_reg <= 1'b1;
        end
        else if (clr_i)
        begin
            flag_reg <= 1'b0;
        end
    end

endmodule // psbs_flag

/* design/psbs_top.v */
// psbs_top.v: status logic of a parallel slave port with four input and
// four output byte buffers, reached by software over apb.
// assumes: external master strobes arrive asynchronously on pins, one per
// buffer; software buffer strobes are single-cycle pulses on pclk.
`include "psbs_defines.vh"

module psbs_top #(
    parameter NBUF = `PSBS_NBUF
)
(
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PSBS_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_reg,
    output reg pready_reg,
    output reg pslverr_reg,
    // external master strobes, asynchronous pins
    input wire [NBUF-1:0] ext_in_wr,
    input wire [NBUF-1:0] ext_out_rd,
    // software side buffer strobes
    input wire [NBUF-1:0] sw_in_rd,
    input wire [NBUF-1:0] sw_out_wr,
    // flags towards the buffer logic
    output wire [NBUF-1:0] in_buf_full_n,
    output wire [NBUF-1:0] out_buf_empty_n,
    output reg slave_en_reg,
    // interrupt
    output reg irq_reg
);

    // synchronisers and edge detection of the pin strobes
    reg [NBUF-1:0] in_wr_meta_reg;
    reg [NBUF-1:0] in_wr_sync_reg;
    reg [NBUF-1:0] in_wr_last_reg;
    reg [NBUF-1:0] out_rd_meta_reg;
    reg [NBUF-1:0] out_rd_sync_reg;
    reg [NBUF-1:0] out_rd_last_reg;
    wire [NBUF-1:0] ext_wr_pulse;
    wire [NBUF-1:0] ext_rd_pulse;

    // status and interrupt state
    reg in_overflow_reg;
    reg out_underflow_reg;
    reg in_overflow_next;
    reg out_underflow_next;
    reg [`PSBS_INT_W-1:0] int_status_reg;
    reg [`PSBS_INT_W-1:0] int_status_next;
    reg [`PSBS_INT_W-1:0] int_mask_reg;
    reg [`PSBS_INT_W-1:0] int_taken_reg;
    reg in_all_full_last_reg;
    reg out_all_empty_last_reg;
    wire in_all_full;
    wire out_all_empty;
    wire overflow_evt;
    wire underflow_evt;
    wire [`PSBS_INT_W-1:0] int_events;

    // bus decode
    wire access;
    wire capture;
    wire done;
    wire wr_done;
    wire rd_done;
    reg addr_ok;
    reg [31:0] rdata_mux;
    wire [31:0] status_word;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_wr_meta_reg <= {NBUF{1'b0}};
            in_wr_sync_reg <= {NBUF{1'b0}};
            in_wr_last_reg <= {NBUF{1'b0}};
            out_rd_meta_reg <= {NBUF{1'b0}};
            out_rd_sync_reg <= {NBUF{1'b0}};
            out_rd_last_reg <= {NBUF{1'b0}};
        end
        else
        begin
            in_wr_meta_reg <= ext_in_wr;
            in_wr_sync_reg <= in_wr_meta_reg;
            in_wr_last_reg <= in_wr_sync_reg;
            out_rd_meta_reg <= ext_out_rd;
            out_rd_sync_reg <= out_rd_meta_reg;
            out_rd_last_reg <= out_rd_sync_reg;
        end
    end

    // outside slave mode the external strobes are ignored
    assign ext_wr_pulse = (in_wr_sync_reg & ~in_wr_last_reg) &
                          {NBUF{slave_en_reg}};
    assign ext_rd_pulse = (out_rd_sync_reg & ~out_rd_last_reg) &
                          {NBUF{slave_en_reg}};

    // per-buffer flags
    genvar i;
    generate
        for (i = 0; i < NBUF; i = i + 1)
        begin : g_buf
            psbs_flag #(
                .RESET_VAL(1'b0)
            ) u_in_full (
                .pclk(pclk),
                .presetn(presetn),
                .set_i(ext_wr_pulse[i]),
                .clr_i(sw_in_rd[i]),
                .flag_reg(in_buf_full_n[i])
            );
            psbs_flag #(
                .RESET_VAL(1'b1)
            ) u_out_empty (
                .pclk(pclk),
                .presetn(presetn),
                .set_i(ext_rd_pulse[i]),
                .clr_i(sw_out_wr[i]),
                .flag_reg(out_buf_empty_n[i])
            );
        end
    endgenerate

    assign in_all_full = &in_buf_full_n;
    assign out_all_empty = &out_buf_empty_n;

    // a write hitting an already full buffer, a read of an empty one
    assign overflow_evt = |(ext_wr_pulse & in_buf_full_n);
    assign underflow_evt = |(ext_rd_pulse & out_buf_empty_n);

    // apb phases: one wait state, so read data is captured a cycle early
    assign access = psel & penable;
    assign capture = access & ~pready_reg;
    assign done = access & pready_reg;
    assign wr_done = done & pwrite & addr_ok;
    assign rd_done = done & ~pwrite & addr_ok;

    always @*
    begin
        case (paddr)
            `PSBS_OFS_STATUS: addr_ok = 1'b1;
            `PSBS_OFS_CTRL: addr_ok = 1'b1;
            `PSBS_OFS_INT_STATUS: addr_ok = 1'b1;
            `PSBS_OFS_INT_MASK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // error flags: hardware sets, software clears by writing 0
    always @*
    begin
        in_overflow_next = in_overflow_reg;
        out_underflow_next = out_underflow_reg;
        if (wr_done && paddr == `PSBS_OFS_STATUS)
        begin
            if (!pwdata[`PSBS_BIT_IN_OVERFLOW])
            begin
                in_overflow_next = 1'b0;
            end
            if (!pwdata[`PSBS_BIT_OUT_UNDERFLOW])
            begin
                out_underflow_next = 1'b0;
            end
        end
        if (overflow_evt)
        begin
            in_overflow_next = 1'b1;
        end
        if (underflow_evt)
        begin
            out_underflow_next = 1'b1;
        end
    end

    // read-only fields ignore writes; unimplemented bits stay zero
    assign status_word = {16'h0000,
                          in_all_full,
                          in_overflow_reg,
                          2'b00,
                          in_buf_full_n,
                          out_all_empty,
                          out_underflow_reg,
                          2'b00,
                          out_buf_empty_n};

    always @*
    begin
        case (paddr)
            `PSBS_OFS_STATUS: rdata_mux = status_word;
            `PSBS_OFS_CTRL: rdata_mux = {31'h00000000, slave_en_reg};
            `PSBS_OFS_INT_STATUS: rdata_mux = {28'h0000000, int_status_reg};
            `PSBS_OFS_INT_MASK: rdata_mux = {28'h0000000, int_mask_reg};
            default: rdata_mux = 32'h00000000;
        endcase
    end

    // interrupt events: errors and the aggregate flags becoming true
    assign int_events = {out_all_empty & ~out_all_empty_last_reg,
                         in_all_full & ~in_all_full_last_reg,
                         underflow_evt,
                         overflow_evt};

    // a read clears only the bits it returned, so later events survive
    always @*
    begin
        int_status_next = int_status_reg;
        if (rd_done && paddr == `PSBS_OFS_INT_STATUS)
        begin
            int_status_next = int_status_reg & ~int_taken_reg;
        end
        int_status_next = int_status_next | int_events;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_overflow_reg <= 1'b0;
            out_underflow_reg <= 1'b0;
            int_status_reg <= `PSBS_INT_RESET;
            in_all_full_last_reg <= 1'b0;
            out_all_empty_last_reg <= 1'b1;
            irq_reg <= 1'b0;
        end
        else
        begin
            in_overflow_reg <= in_overflow_next;
            out_underflow_reg <= out_underflow_next;
            int_status_reg <= int_status_next;
            in_all_full_last_reg <= in_all_full;
            out_all_empty_last_reg <= out_all_empty;
            irq_reg <= |(int_status_next & int_mask_reg);
        end
    end

    // control and mask registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slave_en_reg <= `PSBS_CTRL_RESET;
            int_mask_reg <= `PSBS_INT_RESET;
        end
        else if (wr_done)
        begin
            if (paddr == `PSBS_OFS_CTRL)
            begin
                slave_en_reg <= pwdata[`PSBS_BIT_SLAVE_EN];
            end
            if (paddr == `PSBS_OFS_INT_MASK)
            begin
                int_mask_reg <= pwdata[`PSBS_INT_W-1:0];
            end
        end
    end

    // bus response
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            int_taken_reg <= `PSBS_INT_RESET;
        end
        else if (capture)
        begin
            pready_reg <= 1'b1;
            pslverr_reg <= ~addr_ok;
            prdata_reg <= pwrite ? 32'h00000000 : rdata_mux;
            int_taken_reg <= int_status_reg;
        end
        else
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end
    end

endmodule // psbs_top

/* test/psbs_props.sv */
// psbs_props.sv: port assertions for the parallel slave status block.
// assumes: bound into psbs_top, single pclk domain, status at 8'h00.
module psbs_props #(
    parameter NBUF = 4
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata_reg,
    input wire logic pready_reg,
    input wire logic pslverr_reg,
    // strobes and flags
    input wire logic [NBUF-1:0] ext_in_wr,
    input wire logic [NBUF-1:0] ext_out_rd,
    input wire logic [NBUF-1:0] sw_in_rd,
    input wire logic [NBUF-1:0] sw_out_wr,
    input wire logic [NBUF-1:0] in_buf_full_n,
    input wire logic [NBUF-1:0] out_buf_empty_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // read data is captured one cycle before pready
    wire logic st_rd = pready_reg && !pwrite && paddr == 8'h00;
    chk_all_full: assert property (st_rd |->
        prdata_reg[15] == &$past(in_buf_full_n)) else $error("in_all_full");
    chk_all_empty: assert property (st_rd |->
        prdata_reg[7] == &$past(out_buf_empty_n)) else $error("out_all_empty");
    chk_field_mirror: assert property (st_rd |->
        prdata_reg[11:8] == $past(in_buf_full_n)
        && prdata_reg[3:0] == $past(out_buf_empty_n)) else $error("fields");
    chk_zero_bits: assert property (st_rd |->
        prdata_reg[31:16] == 16'h0000 && prdata_reg[13:12] == 2'h0
        && prdata_reg[5:4] == 2'h0) else $error("unused bits set");
    chk_in_set_cause: assert property (
        (in_buf_full_n & ~$past(in_buf_full_n) & ~$past(ext_in_wr, 3)) == '0)
        else $error("input full without pin write");
    chk_in_clr_cause: assert property (
        ($past(in_buf_full_n) & ~in_buf_full_n & ~$past(sw_in_rd)) == '0)
        else $error("input full cleared without read");
    chk_out_clr_cause: assert property (
        ($past(out_buf_empty_n) & ~out_buf_empty_n & ~$past(sw_out_wr)) == '0)
        else $error("output empty cleared without write");
    chk_out_set_cause: assert property (
        (out_buf_empty_n & ~$past(out_buf_empty_n) & ~$past(ext_out_rd, 3))
        == '0) else $error("output empty set without pin read");
    // release leaves the flags at their reset levels until an event
    chk_reset_flags: assert property ($rose(presetn) |->
        &out_buf_empty_n && in_buf_full_n == '0)
        else $error("flags after reset");
    chk_one_wait: assert property (psel && $rose(penable) |->
        !pready_reg ##1 pready_reg) else $error("apb wait state");
    cov_refused: cover property (pready_reg && pslverr_reg);
    cov_in_read: cover property ($fell(in_buf_full_n[0]));
    cov_out_read: cover property ($rose(out_buf_empty_n[1]));
endmodule // psbs_props

bind psbs_top psbs_props #(.NBUF(NBUF)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata_reg(prdata_reg),
    .pready_reg(pready_reg), .pslverr_reg(pslverr_reg),
    .ext_in_wr(ext_in_wr), .ext_out_rd(ext_out_rd), .sw_in_rd(sw_in_rd),
    .sw_out_wr(sw_out_wr), .in_buf_full_n(in_buf_full_n),
    .out_buf_empty_n(out_buf_empty_n));

/* test/psbs_ext_master.sv */
// psbs_ext_master.sv: model of the external master's buffer strobe pins.
// assumes: pins idle low; the bench calls strobe() for each access.
module psbs_ext_master
(
    // clock
    input wire logic pclk,
    // strobe pins
    output logic [3:0] ext_in_wr,
    output logic [3:0] ext_out_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        ext_in_wr = 4'h0;
        ext_out_rd = 4'h0;
    end
    // hold of 1 is the fastest pin the synchroniser accepts
    task automatic strobe(input bit rd, input int idx, input int hold);
        @(posedge pclk);
        if (rd) ext_out_rd[idx] <= 1'b1;
        else ext_in_wr[idx] <= 1'b1;
        repeat (hold) @(posedge pclk);
        ext_in_wr <= 4'h0;
        ext_out_rd <= 4'h0;
        // low time plus synchroniser delay before the flag settles
        repeat (4) @(posedge pclk);
    endtask
endmodule // psbs_ext_master

/* test/tb_top.sv */
// tb_top.sv: self-checking bench for psbs_top over apb and strobe pins.
// assumes: psbs_props is bound in, psbs_ext_master drives the pins.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED at %0t: %h vs %h", $time, a, b); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, q;
    logic [3:0] sw_in_rd = 4'h0, sw_out_wr = 4'h0;
    wire [3:0] ext_in_wr, ext_out_rd, in_full, out_empty;
    wire [31:0] prdata;
    wire pready, pslverr, slave_en, irq;
    int num_errors = 0, checks = 0;
    always #10 pclk = ~pclk;
    psbs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_reg(prdata), .pready_reg(pready), .pslverr_reg(pslverr),
        .ext_in_wr(ext_in_wr), .ext_out_rd(ext_out_rd), .sw_in_rd(sw_in_rd),
        .sw_out_wr(sw_out_wr), .in_buf_full_n(in_full),
        .out_buf_empty_n(out_empty), .slave_en_reg(slave_en), .irq_reg(irq));
    psbs_ext_master u_ext (.pclk(pclk), .ext_in_wr(ext_in_wr),
        .ext_out_rd(ext_out_rd));
    task automatic report_and_stop();
        $display("errors %0d, checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [31:0] st(logic [3:0] i, logic ov, logic [3:0] o,
        logic uf);
        return {16'h0000, &i, ov, 2'h0, i, &o, uf, 2'h0, o};
    endfunction
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1 && ++n < 20);
        if (pready !== 1'b1)
        begin
            num_errors++;
            report_and_stop();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic sw(input logic [3:0] r, input logic [3:0] w);
        @(posedge pclk);
        sw_in_rd <= r;
        sw_out_wr <= w;
        @(posedge pclk);
        sw_in_rd <= 4'h0;
        sw_out_wr <= 4'h0;
    endtask
    task automatic t_reset();
        apb(0, 8'h00, 32'h0);
        `CHK(q, 32'h0000008F)
        apb(0, 8'h10, 32'h0);
        `CHK(e, 1'b1)
        `CHK(q, 32'h0)
        // pins are ignored until slave mode is on
        u_ext.strobe(0, 0, 2);
        apb(0, 8'h00, 32'h0);
        `CHK(q, 32'h0000008F)
    endtask
    task automatic t_fill();
        apb(1, 8'h04, 32'h1);
        apb(1, 8'h0C, 32'h5);
        for (int i = 0; i < 4; i++)
        begin
            u_ext.strobe(0, i, 2 + i);
            apb(0, 8'h00, 32'h0);
            `CHK(q, st(4'hF >> (3 - i), 0, 4'hF, 0))
        end
        `CHK(in_full, 4'hF)
        apb(0, 8'h08, 32'h0);
        `CHK(q[3:0], 4'h4)
        u_ext.strobe(0, 2, 2);
        apb(0, 8'h00, 32'h0);
        `CHK(q, st(4'hF, 1, 4'hF, 0))
        `CHK(irq, 1'b1)
        apb(1, 8'h00, 32'hFFFFFFFF);
        apb(0, 8'h00, 32'h0);
        `CHK(q, st(4'hF, 1, 4'hF, 0))
        apb(1, 8'h00, 32'h0);
        apb(0, 8'h00, 32'h0);
        `CHK(q, st(4'hF, 0, 4'hF, 0))
        apb(0, 8'h08, 32'h0);
        `CHK(q[3:0], 4'h1)
        @(negedge pclk);
        `CHK(irq, 1'b0)
        sw(4'h5, 4'h0);
        apb(0, 8'h00, 32'h0);
        `CHK(q, st(4'hA, 0, 4'hF, 0))
        sw(4'hA, 4'h0);
    endtask
    task automatic t_drain();
        apb(1, 8'h0C, 32'h1);
        sw(4'h0, 4'h3);
        apb(0, 8'h00, 32'h0);
        `CHK(q, st(4'h0, 0, 4'hC, 0))
        sw(4'h0, 4'hC);
        apb(0, 8'h00, 32'h0);
        `CHK(q, st(4'h0, 0, 4'h0, 0))
        u_ext.strobe(1, 1, 2);
        u_ext.strobe(1, 1, 5);
        apb(0, 8'h00, 32'h0);
        `CHK(q, st(4'h0, 0, 4'h2, 1))
        `CHK(out_empty, 4'h2)
        `CHK(irq, 1'b0)
        apb(0, 8'h08, 32'h0);
        `CHK(q[3:0], 4'h2)
        apb(1, 8'h00, 32'h0);
        apb(0, 8'h00, 32'h0);
        `CHK(q, st(4'h0, 0, 4'h2, 0))
        // draining the rest raises the all-empty interrupt
        apb(1, 8'h0C, 32'h8);
        u_ext.strobe(1, 0, 2);
        u_ext.strobe(1, 2, 2);
        u_ext.strobe(1, 3, 2);
        `CHK(out_empty, 4'hF)
        `CHK(irq, 1'b1)
        apb(0, 8'h08, 32'h0);
        `CHK(q[3:0], 4'h8)
        apb(0, 8'h04, 32'h0);
        `CHK(q, 32'h1)
        `CHK(slave_en, 1'b1)
    endtask
    task automatic t_rerun();
        sw(4'h0, 4'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK(out_empty, 4'hF)
        `CHK(in_full, 4'h0)
        `CHK(irq, 1'b0)
        `CHK(slave_en, 1'b0)
        presetn <= 1'b1;
        apb(0, 8'h00, 32'h0);
        `CHK(q, 32'h0000008F)
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fill();
        t_drain();
        t_rerun();
        report_and_stop();
    end
endmodule // tb_top
